// file: common/psfd_defines.svh
// constants for the packed single-float datapath
// assumes ieee single-precision lanes, four to a vector
`ifndef PSFD_DEFINES_SVH
`define PSFD_DEFINES_SVH

// default quiet nan returned by invalid arithmetic
`define PSFD_QNAN       32'h7FC00000
// magic offsets for the bit-trick approximations
`define PSFD_RCP_MAGIC  32'h7EF311C3
`define PSFD_RSQ_MAGIC  32'h5F3759DF
// exponent bias, all-ones exponent
`define PSFD_BIAS       10'h07F
`define PSFD_EXP_MAX    10'h0FF
// iteration counts of the divide and root engine
`define PSFD_DIV_STEPS  5'h19
`define PSFD_SQRT_STEPS 5'h18

`endif

// file: common/psfd_pkg.sv
// types shared by the packed single-float datapath
// assumes psfd_defines.svh on the include path
`include "psfd_defines.svh"
package psfd_pkg;

  typedef enum logic [4:0] {
    OP_MASK  = 5'h00, OP_MOVHL = 5'h01,
    OP_PADD  = 5'h02, OP_SADD  = 5'h03,
    OP_PSUB  = 5'h04, OP_SSUB  = 5'h05,
    OP_PMUL  = 5'h06, OP_SMUL  = 5'h07,
    OP_PDIV  = 5'h08, OP_SDIV  = 5'h09,
    OP_PRCP  = 5'h0A, OP_SRCP  = 5'h0B,
    OP_PSQRT = 5'h0C, OP_SSQRT = 5'h0D,
    OP_PRSQ  = 5'h0E, OP_SRSQ  = 5'h0F,
    OP_PMAX  = 5'h10, OP_SMAX  = 5'h11,
    OP_PMIN  = 5'h12, OP_SMIN  = 5'h13,
    OP_AND   = 5'h14, OP_ANDN  = 5'h15,
    OP_OR    = 5'h16, OP_XOR   = 5'h17,
    OP_PCMP  = 5'h18, OP_SCMP  = 5'h19,
    OP_OCOMI = 5'h1A, OP_UCOMI = 5'h1B,
    OP_SHUF  = 5'h1C, OP_UNPH  = 5'h1D,
    OP_UNPL  = 5'h1E
  } psfd_op_t;

  typedef enum logic [2:0] {
    PR_EQ  = 3'h0, PR_LT  = 3'h1, PR_LE  = 3'h2, PR_UN  = 3'h3,
    PR_NEQ = 3'h4, PR_NLT = 3'h5, PR_NLE = 3'h6, PR_ORD = 3'h7
  } psfd_pred_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_ITER = 1'b1
  } psfd_state_t;

  // packs sign, biased exponent and fraction, clamping to zero or infinity
  function automatic logic [31:0] psfd_pack(input logic s, input logic signed [9:0] e, input logic [22:0] f);
    if (e <= 10'sh000) return {s, 31'h00000000};
    if (e >= $signed(`PSFD_EXP_MAX)) return {s, 8'hFF, 23'h000000};
    return {s, e[7:0], f};
  endfunction

endpackage

// file: hw/psfd_cmp.sv
// lane compare: orders two single-precision values
// assumes denormals are treated as zero
`timescale 1ns/1ps
module psfd_cmp
  import psfd_pkg::*;
(
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic             lt,
  output logic             eq,
  output logic             unord,
  output logic             snan
);
  logic na, nb, za, zb;

  always_comb begin
    na    = (&a[30:23]) & (|a[22:0]);
    nb    = (&b[30:23]) & (|b[22:0]);
    za    = a[30:23] == 8'h00;
    zb    = b[30:23] == 8'h00;
    unord = na | nb;
    snan  = (na & ~a[22]) | (nb & ~b[22]);
    eq    = ~unord & ((a == b) | (za & zb));
    lt    = 1'b0;
    if (!unord && !eq) begin
      unique case ({a[31], b[31]})
        2'b10:   lt = 1'b1;
        2'b00:   lt = a[30:0] < b[30:0];
        2'b11:   lt = b[30:0] < a[30:0];
        2'b01:   lt = 1'b0;
      endcase
    end
  end

endmodule // psfd_cmp

// file: hw/psfd_iter.sv
// iterative divide and square root for one lane
// assumes start is a one-cycle pulse and operands stand with it
`timescale 1ns/1ps
`include "psfd_defines.svh"
module psfd_iter
  import psfd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        is_sqrt,
  input  wire logic [31:0] num,
  input  wire logic [31:0] den,
  output logic             done_q,
  output logic [31:0]      res_q
);
  logic        busy_q, fin_q, sqrt_q, sgn_q, sp_q;
  logic [4:0]  cnt_q;
  logic [9:0]  exp_q, ud, ex;
  logic [23:0] dv_q, mn, md;
  logic [24:0] q_q;
  logic [27:0] rem_q, r2, tr, nrem;
  logic [47:0] rad_q;
  logic [31:0] spv_q, spv;
  logic        sp, nn, nd, in_n, in_d, zn, zd, sg, ge;

  // operand classes and early answers
  always_comb begin
    zn   = num[30:23] == 8'h00;
    zd   = den[30:23] == 8'h00;
    in_n = &num[30:23];
    in_d = &den[30:23];
    nn   = in_n & (|num[22:0]);
    nd   = in_d & (|den[22:0]);
    mn   = zn ? 24'h000000 : {1'b1, num[22:0]};
    md   = zd ? 24'h000000 : {1'b1, den[22:0]};
    ud   = {2'b00, den[30:23]} - `PSFD_BIAS;
    sg   = is_sqrt ? 1'b0 : num[31] ^ den[31];
    sp   = 1'b0;
    spv  = `PSFD_QNAN;
    if (is_sqrt) begin
      ex = 10'($signed(ud) >>> 1) + `PSFD_BIAS + 10'h001;
      if (nd || (den[31] && !zd)) begin
        sp = 1'b1;
      end else if (in_d || zd) begin
        sp  = 1'b1;
        spv = den;
      end
    end else begin
      ex = {2'b00, num[30:23]} - {2'b00, den[30:23]} + `PSFD_BIAS;
      if (nn || nd || (in_n && in_d) || (zn && zd)) begin
        sp = 1'b1;
      end else if (in_n || zd) begin
        sp  = 1'b1;
        spv = {sg, 8'hFF, 23'h000000};
      end else if (zn || in_d) begin
        sp  = 1'b1;
        spv = {sg, 31'h00000000};
      end
    end
  end

  // one quotient or root bit per cycle
  always_comb begin
    r2 = {rem_q[25:0], rad_q[47:46]};
    tr = {2'b00, q_q[23:0], 2'b01};
    if (sqrt_q) begin
      ge   = r2 >= tr;
      nrem = ge ? r2 - tr : r2;
    end else begin
      ge   = rem_q >= {4'h0, dv_q};
      nrem = (ge ? rem_q - {4'h0, dv_q} : rem_q) << 1;
    end
  end

  // ******************************************
  // sequence control
  // ******************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      fin_q  <= 1'b0;
      cnt_q  <= 5'h00;
    end else if (start) begin
      busy_q <= 1'b1;
      fin_q  <= 1'b0;
      cnt_q  <= is_sqrt ? `PSFD_SQRT_STEPS : `PSFD_DIV_STEPS;
    end else begin
      fin_q <= busy_q && cnt_q == 5'h01;
      if (busy_q) begin
        cnt_q <= cnt_q - 5'h01;
      end
      if (busy_q && cnt_q == 5'h01) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ******************************************
  // datapath
  // ******************************************
  always_ff @(posedge ref_clk) begin
    if (start) begin
      sqrt_q <= is_sqrt;
      sgn_q  <= sg;
      sp_q   <= sp;
      spv_q  <= spv;
      exp_q  <= ex;
      dv_q   <= md;
      q_q    <= 25'h0000000;
      rem_q  <= is_sqrt ? 28'h0000000 : {4'h0, mn};
      rad_q  <= ud[0] ? {md, 24'h000000} : {1'b0, md, 23'h000000};
    end else if (busy_q) begin
      q_q   <= {q_q[23:0], ge};
      rem_q <= nrem;
      rad_q <= rad_q << 2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_q <= 1'b0;
      res_q  <= 32'h00000000;
    end else begin
      done_q <= fin_q;
      if (fin_q) begin
        res_q <= sp_q ? spv_q : psfd_pack(sgn_q, q_q[24] ? exp_q : exp_q - 10'h001,
                                          q_q[24] ? q_q[23:1] : q_q[22:0]);
      end
    end
  end

endmodule // psfd_iter

// file: hw/psfd_datapath.sv
// packed single-float execution datapath, four lanes of a vector register
// assumes the core holds op_* stable while op_valid is high and op_ready_q is low
//
// What this block does
// RULE1 - mask extract gathers four lane signs, lane0 bit0
// RULE2 - high-to-low copies source upper quad to lower
// RULE3 - packed add/subtract works on all four lanes
// RULE4 - scalar add/subtract works on lowest lane only
// RULE5 - scalar ops keep upper lanes of first operand
// RULE6 - multiply per lane, or lowest lane when scalar
// RULE7 - divide first by second, packed or scalar
// RULE8 - reciprocal gives an approximation, not rounded
// RULE9 - square root per lane, packed or scalar
// RULE10 - inverse square root gives an approximation
// RULE11 - packed maximum keeps greater of each pair
// RULE12 - packed minimum keeps lesser of each pair
// RULE13 - scalar maximum/minimum on lowest lanes only
// RULE14 - bitwise and, and-not, or, xor on 128 bits
// RULE15 - predicate compare writes all-ones or zeros mask
// RULE16 - immediate picks one of eight predicates
// RULE17 - scalar predicate compare masks lowest lane only
// RULE18 - flag compare reports via zero, parity, carry
// RULE19 - unordered 111, greater 000, less carry, equal zero
// RULE20 - ordered flag compare invalid on any nan
// RULE21 - unordered flag compare invalid on signalling nan
// RULE22 - shuffle: low lanes from dest, high from source
// RULE23 - shuffle selectors are immediate bit pairs
// RULE24 - high unpack interleaves upper lanes
// RULE25 - low unpack interleaves lower lanes
// RULE26 - unpack order dest, source, dest, source
`timescale 1ns/1ps
`include "psfd_defines.svh"
module psfd_datapath
  import psfd_pkg::*;
#(
  parameter int LANES = 4
)
(
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         op_valid,
  input  wire psfd_op_t     op_code,
  input  wire logic [127:0] op_dst,
  input  wire logic [127:0] op_src,
  input  wire logic [7:0]   op_imm,
  output logic              op_ready_q,
  output logic              res_valid_q,
  output logic [127:0]      res_vec_q,
  output logic              gpr_valid_q,
  output logic [31:0]       gpr_q,
  output logic              flags_valid_q,
  output logic              zero_flag_q,
  output logic              parity_flag_q,
  output logic              carry_flag_q,
  output logic              invalid_q
);

  // ******************************************
  // arithmetic helpers
  // ******************************************
  function automatic logic [31:0] fadd(input logic [31:0] x, input logic [31:0] y);
    logic [31:0]        p;
    logic [31:0]        q;
    logic [7:0]         d;
    logic [23:0]        mp;
    logic [23:0]        mq;
    logic [24:0]        s;
    logic [24:0]        sn;
    logic signed [9:0]  e;
    logic [4:0]         lz;
    logic               sub;
    logic               nan;
    if (x[30:0] < y[30:0]) begin
      p = y;
      q = x;
    end else begin
      p = x;
      q = y;
    end
    sub = p[31] ^ q[31];
    d   = p[30:23] - q[30:23];
    mp  = (p[30:23] == 8'h00) ? 24'h000000 : {1'b1, p[22:0]};
    mq  = (q[30:23] == 8'h00) ? 24'h000000 : {1'b1, q[22:0]};
    mq  = mq >> d;
    s   = sub ? {1'b0, mp} - {1'b0, mq} : {1'b0, mp} + {1'b0, mq};
    e   = $signed({2'b00, p[30:23]});
    lz  = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (s[i]) begin
        lz = 5'(23 - i);
      end
    end
    sn  = s << lz;
    nan = ((&p[30:23]) & (|p[22:0])) | ((&q[30:23]) & (|q[22:0]));
    if (nan || ((&p[30:23]) && (&q[30:23]) && sub)) begin
      return `PSFD_QNAN;
    end
    if (&p[30:23]) begin
      return p;
    end
    if (s == 25'h0000000) begin
      return 32'h00000000;
    end
    if (s[24]) begin
      return psfd_pack(p[31], e + 10'sh001, s[23:1]);
    end
    return psfd_pack(p[31], e - $signed({5'h00, lz}), sn[22:0]);
  endfunction

  function automatic logic [31:0] fmul(input logic [31:0] x, input logic [31:0] y);
    logic [47:0]       pr;
    logic signed [9:0] e;
    logic              s;
    logic              ix;
    logic              iy;
    logic              zx;
    logic              zy;
    s  = x[31] ^ y[31];
    ix = &x[30:23];
    iy = &y[30:23];
    zx = x[30:23] == 8'h00;
    zy = y[30:23] == 8'h00;
    pr = {1'b1, x[22:0]} * {1'b1, y[22:0]};
    e  = $signed({2'b00, x[30:23]} + {2'b00, y[30:23]} - `PSFD_BIAS);
    if ((ix && |x[22:0]) || (iy && |y[22:0]) || (ix && zy) || (iy && zx)) begin
      return `PSFD_QNAN;
    end
    if (ix || iy) begin
      return {s, 8'hFF, 23'h000000};
    end
    if (zx || zy) begin
      return {s, 31'h00000000};
    end
    if (pr[47]) begin
      return psfd_pack(s, e + 10'sh001, pr[46:24]);
    end
    return psfd_pack(s, e, pr[45:23]);
  endfunction

  function automatic logic pred_hit(input psfd_pred_t pr, input logic lt, input logic eq, input logic un);
    unique case (pr)
      PR_EQ:  return eq;
      PR_LT:  return lt;
      PR_LE:  return lt | eq;
      PR_UN:  return un;
      PR_NEQ: return ~eq;
      PR_NLT: return ~lt;
      PR_NLE: return ~(lt | eq);
      PR_ORD: return ~un;
    endcase
  endfunction

  // ******************************************
  // operation classes
  // ******************************************
  psfd_state_t  st_q;
  logic         take;
  logic         is_scal;
  logic         is_sub;
  logic         is_iter;
  logic         is_sqrt;
  logic         is_flag;
  logic         is_vec;
  logic         pend_scal_q;
  logic [127:0] pend_dst_q;
  logic [127:0] vec_res;
  logic [127:0] iter_vec;
  logic [31:0]  dst_ln [LANES];
  logic [31:0]  src_ln [LANES];
  logic [LANES-1:0] it_done;
  logic [LANES-1:0] ln_lt;
  logic [LANES-1:0] ln_eq;
  logic [LANES-1:0] ln_un;
  logic [LANES-1:0] ln_sn;

  assign take = op_valid & op_ready_q;

  always_comb begin
    is_scal = 1'b0;
    is_sub  = 1'b0;
    is_iter = 1'b0;
    is_sqrt = 1'b0;
    is_flag = 1'b0;
    unique case (op_code)
      OP_SADD, OP_SMUL, OP_SRCP, OP_SRSQ, OP_SMAX, OP_SMIN, OP_SCMP: is_scal = 1'b1;
      OP_SSUB: begin
        is_scal = 1'b1;
        is_sub  = 1'b1;
      end
      OP_PSUB: is_sub = 1'b1;
      OP_PDIV: is_iter = 1'b1;
      OP_SDIV: begin
        is_iter = 1'b1;
        is_scal = 1'b1;
      end
      OP_PSQRT: begin
        is_iter = 1'b1;
        is_sqrt = 1'b1;
      end
      OP_SSQRT: begin
        is_iter = 1'b1;
        is_sqrt = 1'b1;
        is_scal = 1'b1;
      end
      OP_OCOMI, OP_UCOMI: is_flag = 1'b1;
      default: is_scal = 1'b0;
    endcase
    is_vec = ~is_iter & ~is_flag & (op_code != OP_MASK);
  end

  // ******************************************
  // per-lane datapath
  // ******************************************
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [31:0] it_res;
    logic        pt;

    assign dst_ln[i] = op_dst[32*i +: 32];
    assign src_ln[i] = op_src[32*i +: 32];
    assign a         = dst_ln[i];
    assign b         = src_ln[i];
    assign pt        = pred_hit(psfd_pred_t'(op_imm[2:0]), ln_lt[i], ln_eq[i], ln_un[i]); // [RULE16]

    psfd_cmp u_cmp (
      .a     (a),
      .b     (b),
      .lt    (ln_lt[i]),
      .eq    (ln_eq[i]),
      .unord (ln_un[i]),
      .snan  (ln_sn[i])
    );

    psfd_iter u_iter (
      .ref_clk (ref_clk),
      .reset   (reset),
      .start   (take & is_iter),
      .is_sqrt (is_sqrt),
      .num     (a),
      .den     (b),
      .done_q  (it_done[i]),
      .res_q   (it_res)
    ); // [RULE7] [RULE9]

    always_comb begin
      unique case (op_code)
        OP_PADD, OP_SADD, OP_PSUB, OP_SSUB: r = fadd(a, b ^ {is_sub, 31'h00000000}); // [RULE3] [RULE4]
        OP_PMUL, OP_SMUL: r = fmul(a, b); // [RULE6]
        OP_PRCP, OP_SRCP: r = `PSFD_RCP_MAGIC - b; // [RULE8]
        OP_PRSQ, OP_SRSQ: r = `PSFD_RSQ_MAGIC - {1'b0, b[31:1]}; // [RULE10]
        OP_PMAX, OP_SMAX: r = (~ln_lt[i] & ~ln_eq[i] & ~ln_un[i]) ? a : b; // [RULE11] [RULE13]
        OP_PMIN, OP_SMIN: r = ln_lt[i] ? a : b; // [RULE12] [RULE13]
        OP_AND:  r = a & b; // [RULE14]
        OP_ANDN: r = ~a & b; // [RULE14]
        OP_OR:   r = a | b; // [RULE14]
        OP_XOR:  r = a ^ b; // [RULE14]
        OP_PCMP, OP_SCMP: r = {32{pt}}; // [RULE15] [RULE17]
        OP_SHUF: r = (i < 2) ? dst_ln[op_imm[2*i +: 2]] : src_ln[op_imm[2*i +: 2]]; // [RULE22] [RULE23]
        OP_UNPH: r = (i % 2 == 0) ? dst_ln[i/2 + 2] : src_ln[i/2 + 2]; // [RULE24] [RULE26]
        OP_UNPL: r = (i % 2 == 0) ? dst_ln[i/2] : src_ln[i/2]; // [RULE25] [RULE26]
        OP_MOVHL: r = (i < 2) ? src_ln[(i + 2) % LANES] : a; // [RULE2]
        default: r = a;
      endcase
      if (is_scal && i != 0) begin
        r = a; // [RULE5]
      end
    end

    assign vec_res[32*i +: 32]  = r;
    assign iter_vec[32*i +: 32] = (pend_scal_q && i != 0) ? pend_dst_q[32*i +: 32] : it_res; // [RULE5]
  end

  // ******************************************
  // sequencing
  // ******************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q       <= ST_IDLE;
      op_ready_q <= 1'b1;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (take && is_iter) begin
            st_q       <= ST_ITER;
            op_ready_q <= 1'b0;
          end
        end
        ST_ITER: begin
          if (it_done[0]) begin
            st_q       <= ST_IDLE;
            op_ready_q <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_scal_q <= 1'b0;
      pend_dst_q  <= 128'h0;
    end else if (take && is_iter) begin
      pend_scal_q <= is_scal;
      pend_dst_q  <= op_dst;
    end
  end

  // ******************************************
  // vector result
  // ******************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      res_valid_q <= 1'b0;
      res_vec_q   <= 128'h0;
    end else begin
      res_valid_q <= (take & is_vec) | ((st_q == ST_ITER) & it_done[0]);
      if (take && is_vec) begin
        res_vec_q <= vec_res;
      end else if (st_q == ST_ITER && it_done[0]) begin
        res_vec_q <= iter_vec; // [RULE7] [RULE9]
      end
    end
  end

  // ******************************************
  // sign mask to general register
  // ******************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gpr_valid_q <= 1'b0;
      gpr_q       <= 32'h00000000;
    end else begin
      gpr_valid_q <= take & (op_code == OP_MASK);
      if (take && op_code == OP_MASK) begin
        gpr_q <= {28'h0000000, op_src[127], op_src[95], op_src[63], op_src[31]}; // [RULE1]
      end
    end
  end

  // ******************************************
  // status flags
  // ******************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_valid_q <= 1'b0;
      invalid_q     <= 1'b0;
      zero_flag_q   <= 1'b0;
      parity_flag_q <= 1'b0;
      carry_flag_q  <= 1'b0;
    end else begin
      flags_valid_q <= take & is_flag;
      invalid_q     <= 1'b0;
      if (take && is_flag) begin
        zero_flag_q   <= ln_un[0] | ln_eq[0]; // [RULE18] [RULE19]
        parity_flag_q <= ln_un[0];
        carry_flag_q  <= ln_un[0] | ln_lt[0];
        invalid_q     <= (op_code == OP_OCOMI) ? ln_un[0] : ln_sn[0]; // [RULE20] [RULE21]
      end
    end
  end

endmodule // psfd_datapath

// file: verification/psfd_core_model.sv
// issue side of the core: drives one request and holds it until taken
// assumes issue is called just after a rising edge of ref_clk
`timescale 1ns/1ps
module psfd_core_model
  import psfd_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire logic    op_ready_q,
  output logic         op_valid,
  output psfd_op_t     op_code,
  output logic [127:0] op_dst,
  output logic [127:0] op_src,
  output logic [7:0]   op_imm
);
  initial op_valid = 1'b0;

  // ****************
  // request handshake
  // ****************
  task automatic issue(psfd_op_t c, logic [127:0] d, logic [127:0] s, logic [7:0] i);
    logic rdy;
    op_valid = 1'b1;
    op_code = c;
    op_dst = d;
    op_src = s;
    op_imm = i;
    do begin
      rdy = op_ready_q;
      @(posedge ref_clk);
      #1;
    end while (rdy !== 1'b1);
  endtask
  task automatic idle();
    op_valid = 1'b0;
  endtask
endmodule // psfd_core_model

// file: verification/psfd_datapath_sva.sv
// port assertions for the packed single-float datapath
// assumes it is bound to psfd_datapath, one clock domain
`timescale 1ns/1ps
module psfd_datapath_sva
  import psfd_pkg::*;
(
  input logic         ref_clk,
  input logic         reset,
  input logic         op_valid,
  input psfd_op_t     op_code,
  input logic [127:0] op_dst,
  input logic [127:0] op_src,
  input logic [7:0]   op_imm,
  input logic         op_ready_q,
  input logic         res_valid_q,
  input logic [127:0] res_vec_q,
  input logic         gpr_valid_q,
  input logic [31:0]  gpr_q,
  input logic         flags_valid_q,
  input logic         zero_flag_q,
  input logic         parity_flag_q,
  input logic         carry_flag_q,
  input logic         invalid_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  function automatic logic sn(logic [31:0] x);
    return x[30:22] == 9'h1FE && x[21:0] != 22'h0;
  endfunction

  sequence s_take(psfd_op_t c);
    op_valid && op_ready_q && op_code == c;
  endsequence
  sequence s_busy;
    !op_ready_q [*8];
  endsequence

  property p_mask;
    s_take(OP_MASK) |=> gpr_valid_q && gpr_q == {28'h0, $past(op_src[127]), $past(op_src[95]), $past(op_src[63]), $past(op_src[31])};
  endproperty
  property p_movhl;
    s_take(OP_MOVHL) |=> res_valid_q && res_vec_q == {$past(op_dst[127:64]), $past(op_src[127:64])};
  endproperty
  property p_xor;
    s_take(OP_XOR) |=> res_valid_q && res_vec_q == ($past(op_dst) ^ $past(op_src));
  endproperty
  property p_keep;
    op_valid && op_ready_q && op_code inside {OP_SADD, OP_SSUB, OP_SMUL, OP_SMAX, OP_SMIN, OP_SCMP}
      |=> res_valid_q && res_vec_q[127:32] == $past(op_dst[127:32]);
  endproperty
  property p_flags;
    flags_valid_q |-> {zero_flag_q, parity_flag_q, carry_flag_q} inside {3'h0, 3'h1, 3'h4, 3'h7};
  endproperty
  property p_unph;
    s_take(OP_UNPH) |=> res_vec_q == {$past(op_src[127:96]), $past(op_dst[127:96]), $past(op_src[95:64]), $past(op_dst[95:64])};
  endproperty
  property p_div;
    s_take(OP_PDIV) |=> s_busy ##20 res_valid_q && op_ready_q;
  endproperty
  property p_sqrt;
    s_take(OP_PSQRT) |=> s_busy ##19 res_valid_q && op_ready_q;
  endproperty
  property p_ucomi;
    s_take(OP_UCOMI) |=> flags_valid_q && invalid_q == (sn($past(op_dst[31:0])) || sn($past(op_src[31:0])));
  endproperty

  a_mask: assert property (p_mask) else $error("mask");
  a_movhl: assert property (p_movhl) else $error("high to low");
  a_xor: assert property (p_xor) else $error("xor");
  a_keep: assert property (p_keep) else $error("upper lanes");
  a_flags: assert property (p_flags) else $error("flag pattern");
  a_unph: assert property (p_unph) else $error("high unpack");
  a_div: assert property (p_div) else $error("divide timing");
  a_sqrt: assert property (p_sqrt) else $error("root timing");
  a_ucomi: assert property (p_ucomi) else $error("ucomi invalid");
endmodule // psfd_datapath_sva

bind psfd_datapath psfd_datapath_sva u_sva (.ref_clk, .reset, .op_valid, .op_code, .op_dst, .op_src, .op_imm,
  .op_ready_q, .res_valid_q, .res_vec_q, .gpr_valid_q, .gpr_q, .flags_valid_q, .zero_flag_q, .parity_flag_q,
  .carry_flag_q, .invalid_q);

// file: verification/psfd_datapath_test.sv
// self-checking bench for the packed single-float datapath
// assumes psfd_core_model as issuer and the bound checker
`timescale 1ns/1ps
`include "psfd_defines.svh"
module psfd_datapath_test
  import psfd_pkg::*;
;
  localparam logic [127:0] VA = 128'h40800000_40400000_40000000_3F800000,
    VB = 128'h3F800000_40000000_40400000_40800000,
    VC = 128'h7FC00000_40000000_40000000_40800000,
    VN = 128'h40400000_3F800000_BF800000_C0400000,
    VQ = 128'h41800000_41100000_40800000_3F800000;
  logic         ref_clk, reset, op_valid, op_ready_q, res_valid_q, gpr_valid_q, flags_valid_q;
  logic         zero_flag_q, parity_flag_q, carry_flag_q, invalid_q;
  psfd_op_t     op_code;
  logic [127:0] op_dst, op_src, res_vec_q, d, s, e, f;
  logic [7:0]   op_imm, i;
  logic [31:0]  gpr_q, seed;
  logic [127:0] vq[$];
  logic [31:0]  gq[$];
  logic [3:0]   fq[$];
  int           checks, fail_count, k;

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  psfd_datapath u_dut (.ref_clk, .reset, .op_valid, .op_code, .op_dst, .op_src, .op_imm, .op_ready_q, .res_valid_q,
    .res_vec_q, .gpr_valid_q, .gpr_q, .flags_valid_q, .zero_flag_q, .parity_flag_q, .carry_flag_q, .invalid_q);
  psfd_core_model u_core (.ref_clk, .op_ready_q, .op_valid, .op_code, .op_dst, .op_src, .op_imm);

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // relation rl: 0 less, 1 equal, 2 greater, 3 unordered; p[2] negates
  function automatic logic [31:0] pm(logic [2:0] p, logic [1:0] rl);
    logic [3:0] h;
    h = {rl == 2'h3, rl < 2'h2, rl == 2'h0, rl == 2'h1};
    return {32{p[2] ^ h[p[1:0]]}};
  endfunction
  function automatic logic [31:0] ln(logic [127:0] v, logic [1:0] n);
    return v[32*n +: 32];
  endfunction
  task automatic chk(string n, logic [127:0] ex, logic [127:0] got);
    checks++;
    if (got !== ex) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, ex, got);
    end
  endtask
  task automatic cmp_vec(logic [127:0] ex);
    chk("res_vec_q", ex, res_vec_q);
  endtask
  task automatic cmp_gpr(logic [31:0] ex);
    chk("gpr_q", {96'h0, ex}, {96'h0, gpr_q});
  endtask
  task automatic cmp_flg(logic [3:0] ex);
    chk("flags", {124'h0, ex}, {124'h0, zero_flag_q, parity_flag_q, carry_flag_q, invalid_q});
  endtask
  task automatic vop(psfd_op_t c, logic [127:0] dd, logic [127:0] ss, logic [127:0] ex, logic [7:0] ii = 8'h00);
    vq.push_back(ex);
    u_core.issue(c, dd, ss, ii);
  endtask
  // expected flags are {zero, parity, carry, invalid}
  task automatic fop(psfd_op_t c, logic [31:0] a, logic [31:0] b, logic [3:0] ex);
    fq.push_back(ex);
    u_core.issue(c, {VA[127:32], a}, {VB[127:32], b}, 8'h00);
  endtask
  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************
  // result monitor
  // ****************
  always @(negedge ref_clk) begin
    if (res_valid_q === 1'b1) cmp_vec(vq.size() ? vq.pop_front() : ~res_vec_q);
    if (gpr_valid_q === 1'b1) cmp_gpr(gq.size() ? gq.pop_front() : ~gpr_q);
    if (flags_valid_q === 1'b1) cmp_flg(fq.size() ? fq.pop_front() : 4'hF ^ {zero_flag_q, 3'h0});
  end

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 32'h0000646C;
    checks = 0;
    fail_count = 0;
    reset = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    vop(OP_PADD, VA, VB, {4{32'h40A00000}});
    vop(OP_PSUB, VA, VB, VN);
    vop(OP_SADD, VA, VB, {VA[127:32], 32'h40A00000});
    vop(OP_SSUB, VA, VB, {VA[127:32], 32'hC0400000});
    vop(OP_PMUL, VA, VB, 128'h40800000_40C00000_40C00000_40800000);
    vop(OP_SMUL, VA, VB, {VA[127:32], 32'h40800000});
    vop(OP_PDIV, VA, {4{32'h40000000}}, 128'h40000000_3FC00000_3F800000_3F000000);
    vop(OP_SDIV, VA, {4{32'h40000000}}, {VA[127:32], 32'h3F000000});
    vop(OP_PSQRT, VB, VQ, VA);
    vop(OP_SSQRT, VB, VQ, {VB[127:32], 32'h3F800000});
    vop(OP_PMAX, VN, VB, 128'h40400000_40000000_40400000_40800000);
    vop(OP_PMIN, VN, VB, 128'h3F800000_3F800000_BF800000_C0400000);
    vop(OP_SMAX, VN, VB, {VN[127:32], 32'h40800000});
    vop(OP_SMIN, VN, VB, {VN[127:32], 32'hC0400000});
    for (k = 0; k < 4; k++) begin
      e[32*k +: 32] = `PSFD_RCP_MAGIC - VB[32*k +: 32];
      f[32*k +: 32] = `PSFD_RSQ_MAGIC - (VB[32*k +: 32] >> 1);
    end
    vop(OP_PRCP, VA, VB, e);
    vop(OP_SRCP, VA, VB, {VA[127:32], e[31:0]});
    vop(OP_PRSQ, VA, VB, f);
    vop(OP_SRSQ, VA, VB, {VA[127:32], f[31:0]});
    repeat (4) begin
      d = {xs(), xs(), xs(), xs()};
      s = {xs(), xs(), xs(), xs()};
      i = 8'(xs());
      vop(OP_AND, d, s, d & s, i);
      vop(OP_ANDN, d, s, ~d & s, i);
      vop(OP_OR, d, s, d | s, i);
      vop(OP_XOR, d, s, d ^ s, i);
      vop(OP_MOVHL, d, s, {d[127:64], s[127:64]}, i);
      vop(OP_SHUF, d, s, {ln(s, i[7:6]), ln(s, i[5:4]), ln(d, i[3:2]), ln(d, i[1:0])}, i);
      vop(OP_UNPH, d, s, {s[127:96], d[127:96], s[95:64], d[95:64]}, i);
      vop(OP_UNPL, d, s, {s[63:32], d[63:32], s[31:0], d[31:0]}, i);
      gq.push_back({28'h0, s[127], s[95], s[63], s[31]});
      u_core.issue(OP_MASK, d, s, i);
    end
    for (k = 0; k < 8; k++) begin
      e = {pm(k[2:0], 2'h3), pm(k[2:0], 2'h2), pm(k[2:0], 2'h1), pm(k[2:0], 2'h0)};
      vop(OP_PCMP, VA, VC, e, k[7:0]);
      vop(OP_SCMP, VA, VC, {VA[127:32], pm(k[2:0], 2'h0)}, k[7:0]);
    end
    fop(OP_OCOMI, 32'h3F800000, 32'h40800000, 4'h2);
    fop(OP_OCOMI, 32'h40800000, 32'h3F800000, 4'h0);
    fop(OP_UCOMI, 32'h40000000, 32'h40000000, 4'h8);
    fop(OP_OCOMI, 32'h7FC00000, 32'h3F800000, 4'hF);
    fop(OP_UCOMI, 32'h7FC00000, 32'h3F800000, 4'hE);
    fop(OP_UCOMI, 32'h3F800000, 32'h7FA00000, 4'hF);
    u_core.idle();
    repeat (40) @(posedge ref_clk);
    chk("pending", 128'h0, 128'(vq.size() + gq.size() + fq.size()));
    give_verdict();
  end
endmodule // psfd_datapath_test
